// [rtl/fan_ctrl_pkg.sv]
package fan_ctrl_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int NUM_FANS = 4;
    // pwm: 18 hz nominal, 100 steps of duty
    localparam int PWM_HZ = 18;
    localparam int PWM_STEPS = 100;
    localparam int PWM_STEP_CYC = CLK_HZ / (PWM_HZ * PWM_STEPS);
    // measurement window 125 ms, rotation 4 x 125 ms = 500 ms
    localparam int WINDOW_MS = 125;
    localparam int WINDOW_CYC = CLK_HZ / 1000 * WINDOW_MS;
    localparam int ROTATION_MS = 500;
    localparam int STAGGER_MS = 500;
    localparam int STAGGER_CYC = CLK_HZ / 1000 * STAGGER_MS;
    // glitch delay and fail-safe timeout units
    localparam int GLITCH_UNIT_MS = 1;
    localparam int GLITCH_UNIT_CYC = CLK_HZ / 1000 * GLITCH_UNIT_MS;
    localparam int FAILSAFE_UNIT_MS = 125;
    localparam int FAILSAFE_UNIT_CYC = CLK_HZ / 1000 * FAILSAFE_UNIT_MS;
    // result timer tick in clocks; 16 bits must span one window
    localparam int TICK_CYC = 20;
    // register map, word indices of a plain port
    localparam logic [3:0] ADDR_POWER0 = 4'h0;
    localparam logic [3:0] ADDR_REPORT_EN = 4'h4;
    localparam logic [3:0] ADDR_FAILSAFE_EN = 4'h5;
    localparam logic [3:0] ADDR_GLITCH = 4'h6;
    localparam logic [3:0] ADDR_TIMEOUT = 4'h7;
    localparam logic [3:0] ADDR_RESULT = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'h9;
    localparam logic [3:0] ADDR_MASK = 4'ha;
    localparam logic [3:0] ADDR_EDGE_POL = 4'hb;
    localparam logic [3:0] ADDR_PPR = 4'hc;
    localparam logic [6:0] POWER_FULL = 7'h64;
    localparam logic [7:0] COUNT_INVALID = 8'hff;
    localparam logic [7:0] COUNT_MIN = 8'h03;
    localparam logic [1:0] PPR_RESET = 2'h2;
    localparam logic [7:0] GLITCH_RESET = 8'h01;
    localparam logic [7:0] TIMEOUT_RESET = 8'h08;
    // status bits
    localparam int ST_RESULT = 0;
    localparam int ST_FAILSAFE = 1;
    localparam int ST_STOPPED = 2;
    typedef enum logic [1:0] {MEAS_WAIT, MEAS_RUN} meas_state_t;
endpackage : fan_ctrl_pkg

// [rtl/fan_ctrl.sv]
// The placing of the registers and the address-and-strobe port were left to the implementer.
module fan_ctrl
    import fan_ctrl_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // boot configuration
    input wire logic BOOT_VALID,
    input wire logic [6:0] BOOT_POWER [NUM_FANS],
    // register port
    input wire logic [3:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // fans
    input wire logic [NUM_FANS-1:0] TACH,
    output logic [NUM_FANS-1:0] SWITCH_OUT,
    output logic [NUM_FANS-1:0] SWITCH_OE,
    // result and interrupt
    output logic RESULT_STB,
    output logic IRQ
);
    logic [6:0] power_ff [NUM_FANS];
    logic [NUM_FANS-1:0] report_en_ff, failsafe_en_ff, edge_pol_ff;
    logic [7:0] glitch_ff, timeout_ff;
    logic [1:0] ppr_ff;
    logic [2:0] status_ff, mask_ff;
    logic [31:0] result_ff;
    logic booted_ff;
    logic [NUM_FANS-1:0] tach_s1_ff, tach_s2_ff, tach_s3_ff;
    logic [$clog2(PWM_STEP_CYC)-1:0] step_ff;
    logic [6:0] phase_ff;
    logic [NUM_FANS-1:0] pwm_on;
    logic [$clog2(STAGGER_CYC)-1:0] stagger_cnt_ff;
    logic [2:0] started_ff;
    logic [$clog2(FAILSAFE_UNIT_CYC)-1:0] fs_div_ff;
    logic [7:0] fs_cnt_ff;
    logic failsafe_ff;
    logic [$clog2(WINDOW_CYC)-1:0] win_ff;
    logic [1:0] fan_sel_ff;
    logic [$clog2(GLITCH_UNIT_CYC)-1:0] gl_div_ff;
    logic [7:0] gl_cnt_ff;
    logic [7:0] cyc_cnt_ff;
    logic [15:0] ticks_ff, tick_last_ff;
    meas_state_t meas_ff;
    logic [$clog2(TICK_CYC)-1:0] tick_div_ff;
    logic tick_en;
    logic [2:0] nxt_status;
    logic [NUM_FANS-1:0] tach_edge;
    logic win_end, power_wr, stretch_cap_edge;
    logic [2:0] events;

    assign power_wr = WR && (ADDR < ADDR_REPORT_EN);
    assign win_end = (win_ff == $bits(win_ff)'(WINDOW_CYC - 1));
    // timer ticks slower than the clock, so a full window fits sixteen bits
    assign tick_en = (tick_div_ff == $bits(tick_div_ff)'(TICK_CYC - 1));

    // power and configuration registers
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            for (int i = 0; i < NUM_FANS; i++) begin
                power_ff[i] <= POWER_FULL;
            end
            booted_ff <= 1'b0;
            report_en_ff <= '0;
            failsafe_en_ff <= '0;
            edge_pol_ff <= '0;
            glitch_ff <= GLITCH_RESET;
            timeout_ff <= TIMEOUT_RESET;
            ppr_ff <= PPR_RESET;
            mask_ff <= '0;
        end else begin
            booted_ff <= 1'b1;
            if (!booted_ff && BOOT_VALID) begin
                // boot values above full scale clamp as well
                for (int i = 0; i < NUM_FANS; i++) begin
                    power_ff[i] <= (BOOT_POWER[i] > POWER_FULL) ? POWER_FULL : BOOT_POWER[i];
                end
            end else if (power_wr) begin
                // values above full scale clamp to 100 percent
                power_ff[ADDR[1:0]] <= (WDATA[6:0] > POWER_FULL) ? POWER_FULL : WDATA[6:0];
            end
            if (WR && ADDR == ADDR_REPORT_EN) report_en_ff <= WDATA[NUM_FANS-1:0];
            if (WR && ADDR == ADDR_FAILSAFE_EN) failsafe_en_ff <= WDATA[NUM_FANS-1:0];
            if (WR && ADDR == ADDR_GLITCH) glitch_ff <= WDATA[7:0];
            if (WR && ADDR == ADDR_TIMEOUT) timeout_ff <= WDATA[7:0];
            if (WR && ADDR == ADDR_EDGE_POL) edge_pol_ff <= WDATA[NUM_FANS-1:0];
            if (WR && ADDR == ADDR_PPR) ppr_ff <= WDATA[1:0];
            if (WR && ADDR == ADDR_MASK) mask_ff <= WDATA[2:0];
        end
    end

    // tach synchroniser; first stage read only by second
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            // idle level of a pulled-up tach line, so no false edge follows reset
            tach_s1_ff <= '1;
            tach_s2_ff <= '1;
            tach_s3_ff <= '1;
        end else begin
            tach_s1_ff <= TACH;
            tach_s2_ff <= tach_s1_ff;
            tach_s3_ff <= tach_s2_ff;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_FANS; i++) begin
            // pol 0 counts rising edges, pol 1 falling
            tach_edge[i] = edge_pol_ff[i] ? (tach_s3_ff[i] && !tach_s2_ff[i])
                                          : (!tach_s3_ff[i] && tach_s2_ff[i]);
        end
    end

    // shared pwm timebase, 100 steps per period
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            step_ff <= '0;
            phase_ff <= '0;
        end else if (step_ff == $bits(step_ff)'(PWM_STEP_CYC - 1)) begin
            step_ff <= '0;
            phase_ff <= (phase_ff == POWER_FULL - 7'h01) ? 7'h00 : phase_ff + 7'h01;
        end else begin
            step_ff <= step_ff + 1'b1;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_FANS; i++) begin
            pwm_on[i] = (phase_ff < power_ff[i]) || (failsafe_ff && failsafe_en_ff[i]);
        end
    end

    // start-up stagger; one fan released per 0.5 s
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            stagger_cnt_ff <= '0;
            started_ff <= '0;
        end else if (started_ff < 3'(NUM_FANS)) begin
            if (power_ff[started_ff[1:0]] == 7'h00) begin
                // fans that are off take no slot
                started_ff <= started_ff + 3'h1;
            end else if (started_ff == 3'h0 || stagger_cnt_ff == $bits(stagger_cnt_ff)'(STAGGER_CYC - 1)) begin
                stagger_cnt_ff <= '0;
                started_ff <= started_ff + 3'h1;
            end else begin
                stagger_cnt_ff <= stagger_cnt_ff + 1'b1;
            end
        end
    end

    // host timeout, counted in 125 ms units since last power write
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            fs_div_ff <= '0;
            fs_cnt_ff <= '0;
            failsafe_ff <= 1'b0;
        end else if (power_wr) begin
            fs_div_ff <= '0;
            fs_cnt_ff <= '0;
            failsafe_ff <= 1'b0;
        end else if (fs_div_ff == $bits(fs_div_ff)'(FAILSAFE_UNIT_CYC - 1)) begin
            fs_div_ff <= '0;
            if (fs_cnt_ff != 8'hff) fs_cnt_ff <= fs_cnt_ff + 8'h01;
            if (timeout_ff != 8'h00 && fs_cnt_ff + 8'h01 >= timeout_ff) failsafe_ff <= 1'b1;
        end else begin
            fs_div_ff <= fs_div_ff + 1'b1;
        end
    end

    // measurement window and fan rotation
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            win_ff <= '0;
            fan_sel_ff <= '0;
        end else if (win_end) begin
            win_ff <= '0;
            fan_sel_ff <= fan_sel_ff + 2'h1;
        end else begin
            win_ff <= win_ff + 1'b1;
        end
    end

    // glitch delay, counted from window start (switch forced on)
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            gl_div_ff <= '0;
            gl_cnt_ff <= '0;
        end else if (win_end) begin
            gl_div_ff <= '0;
            gl_cnt_ff <= '0;
        end else if (gl_cnt_ff < glitch_ff) begin
            if (gl_div_ff == $bits(gl_div_ff)'(GLITCH_UNIT_CYC - 1)) begin
                gl_div_ff <= '0;
                gl_cnt_ff <= gl_cnt_ff + 8'h01;
            end else begin
                gl_div_ff <= gl_div_ff + 1'b1;
            end
        end
    end

    // timer tick prescaler, restarted with each window
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            tick_div_ff <= '0;
        end else if (win_end || tick_en) begin
            tick_div_ff <= '0;
        end else begin
            tick_div_ff <= tick_div_ff + 1'b1;
        end
    end

    assign stretch_cap_edge = tach_edge[fan_sel_ff] && (gl_cnt_ff >= glitch_ff);

    // tach counting over the window; ticks of last counted edge
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cyc_cnt_ff <= '0;
            ticks_ff <= '0;
            tick_last_ff <= '0;
        end else if (win_end) begin
            cyc_cnt_ff <= '0;
            ticks_ff <= '0;
            tick_last_ff <= '0;
        end else begin
            if (tick_en && ticks_ff != 16'hffff) ticks_ff <= ticks_ff + 16'h0001;
            if (stretch_cap_edge && cyc_cnt_ff != COUNT_INVALID) begin
                cyc_cnt_ff <= cyc_cnt_ff + 8'h01;
                tick_last_ff <= ticks_ff;
            end
        end
    end

    // stretch from window start until glitch delay and two qualified edges
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            meas_ff <= MEAS_WAIT;
        end else if (win_end) begin
            meas_ff <= report_en_ff[fan_sel_ff + 2'h1] ? MEAS_RUN : MEAS_WAIT;
        end else begin
            case (meas_ff)
                MEAS_WAIT: meas_ff <= MEAS_WAIT;
                MEAS_RUN: begin
                    if (stretch_cap_edge && cyc_cnt_ff >= 8'h01) meas_ff <= MEAS_WAIT;
                end
                default: meas_ff <= MEAS_WAIT;
            endcase
        end
    end

    // result word: {index, count, ticks msb first}
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            result_ff <= '0;
            RESULT_STB <= 1'b0;
        end else begin
            RESULT_STB <= win_end && report_en_ff[fan_sel_ff];
            if (win_end && report_en_ff[fan_sel_ff]) begin
                // tick counter saturated: result not trustworthy
                result_ff <= {6'h00, fan_sel_ff, (ticks_ff == 16'hffff) ? COUNT_INVALID : cyc_cnt_ff,
                              tick_last_ff};
            end
        end
    end

    assign events[ST_RESULT] = win_end && report_en_ff[fan_sel_ff];
    assign events[ST_FAILSAFE] = failsafe_ff && !power_wr;
    assign events[ST_STOPPED] = events[ST_RESULT] && cyc_cnt_ff < COUNT_MIN;

    // sticky status, write one to clear; set wins
    // irq follows the next status so it rises with the bit, not a cycle later
    assign nxt_status = (status_ff & ~((WR && ADDR == ADDR_STATUS) ? WDATA[2:0] : 3'h0)) | events;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            status_ff <= '0;
            IRQ <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            IRQ <= |(nxt_status & mask_ff);
        end
    end

    // switch drive: open drain low side, oe high means switch on
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            SWITCH_OUT <= '0;
            SWITCH_OE <= '0;
        end else begin
            SWITCH_OUT <= '0;
            for (int i = 0; i < NUM_FANS; i++) begin
                // stretch ends with the window at latest
                SWITCH_OE[i] <= (3'(i) < started_ff) && (pwm_on[i] ||
                                (meas_ff == MEAS_RUN && fan_sel_ff == 2'(i) && !win_end));
            end
        end
    end

    // read port, data one cycle later
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            RDATA <= '0;
        end else if (RD) begin
            case (ADDR)
                ADDR_REPORT_EN: RDATA <= {28'h0, report_en_ff};
                ADDR_FAILSAFE_EN: RDATA <= {28'h0, failsafe_en_ff};
                ADDR_GLITCH: RDATA <= {24'h0, glitch_ff};
                ADDR_TIMEOUT: RDATA <= {24'h0, timeout_ff};
                ADDR_RESULT: RDATA <= result_ff;
                ADDR_STATUS: RDATA <= {29'h0, status_ff};
                ADDR_MASK: RDATA <= {29'h0, mask_ff};
                ADDR_EDGE_POL: RDATA <= {28'h0, edge_pol_ff};
                ADDR_PPR: RDATA <= {30'h0, ppr_ff};
                default: begin
                    // power words sit below the report enable word
                    RDATA <= (ADDR < ADDR_REPORT_EN) ? {25'h0, power_ff[ADDR[1:0]]} : '0;
                end
            endcase
        end else begin
            RDATA <= '0;
        end
    end
endmodule : fan_ctrl

// [testbench/fan_ctrl_sva.sv]
module fan_ctrl_sva
    import fan_ctrl_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // watched ports
    input wire logic BOOT_VALID,
    input wire logic [3:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic [NUM_FANS-1:0] SWITCH_OUT,
    input wire logic [NUM_FANS-1:0] SWITCH_OE,
    input wire logic RESULT_STB
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] cyc_ff;
    logic [31:0] gap_ff;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // saturates, so a long run never wraps back into the start-up window
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) cyc_ff <= 32'h0;
        else if (cyc_ff != 32'hffffffff) cyc_ff <= cyc_ff + 32'h1;
    end
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) gap_ff <= 32'h0;
        else if (RESULT_STB) gap_ff <= 32'h0;
        else if (gap_ff < 32'(WINDOW_CYC)) gap_ff <= gap_ff + 32'h1;
    end
    open_drain_a: assert property (SWITCH_OUT == 4'h0)
        else $error("switch output driven high");
    stb_pulse_a: assert property (RESULT_STB |=> !RESULT_STB)
        else $error("result strobe longer than one cycle");
    stb_spacing_a: assert property (RESULT_STB |-> gap_ff >= 32'(WINDOW_CYC - 2))
        else $error("results closer than one window");
    start_stagger_a: assert property ($countones(SWITCH_OE) <= 32'h1 + cyc_ff / 32'(STAGGER_CYC))
        else $error("fans started too close together");
    fan0_start_a: assert property (cyc_ff == 32'h1 && !BOOT_VALID |-> ##[1:4] SWITCH_OE[0])
        else $error("first fan not started at full power");
    power_clamp_a: assert property (WR && ADDR == ADDR_POWER0 && WDATA > 32'h64 ##1
        RD && ADDR == ADDR_POWER0 |=> RDATA == 32'h64)
        else $error("power above full scale not clamped");
    rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data outside its cycle");
    unmapped_read_a: assert property (RD && ADDR > ADDR_PPR |=> RDATA == 32'h0)
        else $error("unmapped read not zero");
endmodule : fan_ctrl_sva

bind fan_ctrl fan_ctrl_sva i_sva (.CLK(CLK), .RST_B(RST_B), .BOOT_VALID(BOOT_VALID), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SWITCH_OUT(SWITCH_OUT), .SWITCH_OE(SWITCH_OE),
    .RESULT_STB(RESULT_STB));

// [testbench/fan_model.sv]
module fan_model
    import fan_ctrl_pkg::*;
(
    // clock
    input wire logic clk,
    // switch state per fan
    input wire logic [NUM_FANS-1:0] powered,
    // tach, open collector with pull-up
    output wire logic [NUM_FANS-1:0] tach
);
    timeunit 1ns;
    timeprecision 1ns;
    for (genvar i = 0; i < NUM_FANS; i++) begin : g_fan
        logic [15:0] cnt = 16'h0;
        logic lvl = 1'b1;
        assign tach[i] = lvl;
        // a fan without power stops, its tach line floats to the pull-up
        always @(posedge clk) begin
            if (!powered[i]) begin
                lvl <= 1'b1;
            end else if (cnt == 16'h0) begin
                lvl <= ~lvl;
                cnt <= 16'h80 << i;
            end else begin
                cnt <= cnt - 16'h1;
            end
        end
    end
endmodule : fan_model

// [testbench/testbench.sv]
module testbench
    import fan_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic boot_valid = 1'b0;
    logic [6:0] boot_power [NUM_FANS] = '{default: 7'h0};
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_seen = 1'b0;
    logic [31:0] rdata;
    logic [NUM_FANS-1:0] tach;
    logic [NUM_FANS-1:0] switch_out;
    logic [NUM_FANS-1:0] switch_oe;
    logic result_stb;
    logic irq;
    logic [31:0] exp_q [$];
    logic [31:0] v;
    logic [31:0] rst_val [16] = '{32'h64, 32'h64, 32'h64, 32'h64, 32'h0, 32'h0, 32'h1, 32'h8,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h2, 32'h0, 32'h0, 32'h0};
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;

    always #50 clk = ~clk;

    fan_ctrl i_dut (.CLK(clk), .RST_B(rst_b), .BOOT_VALID(boot_valid), .BOOT_POWER(boot_power),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .TACH(tach),
        .SWITCH_OUT(switch_out), .SWITCH_OE(switch_oe), .RESULT_STB(result_stb), .IRQ(irq));
    fan_model i_fans (.clk(clk), .powered(switch_oe), .tach(tach));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic results();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge clk);
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        addr <= a;
        rd <= 1'b1;
        wr <= 1'b0;
        @(posedge clk);
    endtask : rd_reg

    task automatic idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_seen) check(rdata, exp_q.pop_front());
        rd_seen <= rd;
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            results();
        end
    end

    initial begin
        void'($urandom(89844));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        idle(2);
        @(posedge clk);
        for (int a = 0; a < 16; a++) rd_reg(4'(a), rst_val[a]);
        wr_reg(ADDR_POWER0, 32'h7f);
        rd_reg(ADDR_POWER0, 32'h64);
        for (int i = 0; i < NUM_FANS; i++) begin
            // nonzero, so a zero power never hands fan 1 its stagger slot early
            v = $urandom_range(127, 1);
            wr_reg(ADDR_POWER0 + 4'(i), v);
            rd_reg(ADDR_POWER0 + 4'(i), (v > 32'h64) ? 32'h64 : v);
        end
        wr_reg(4'he, 32'hffffffff);
        rd_reg(4'he, 32'h0);
        v = $urandom_range(15, 0);
        wr_reg(ADDR_EDGE_POL, v);
        rd_reg(ADDR_EDGE_POL, v);
        wr_reg(ADDR_GLITCH, 32'h5);
        wr_reg(ADDR_TIMEOUT, 32'h3);
        rd_reg(ADDR_GLITCH, 32'h5);
        rd_reg(ADDR_TIMEOUT, 32'h3);
        wr_reg(ADDR_PPR, 32'h1);
        rd_reg(ADDR_PPR, 32'h1);
        // nothing pending yet, so unmasking must not raise the line
        wr_reg(ADDR_MASK, 32'h7);
        wr_reg(ADDR_STATUS, 32'h7);
        rd_reg(ADDR_MASK, 32'h7);
        rd_reg(ADDR_STATUS, 32'h0);
        idle(3);
        check({31'h0, irq}, 32'h0);
        @(posedge clk);
        wr_reg(ADDR_POWER0, 32'h0);
        idle(10);
        check(32'(switch_oe), 32'h0);
        @(posedge clk);
        v = $urandom_range(100, 30);
        wr_reg(ADDR_POWER0 + 4'h1, v);
        wr_reg(ADDR_POWER0, 32'h64);
        idle(10);
        check(32'(switch_oe), 32'h1);
        check(32'(switch_out), 32'h0);
        // second reset in mid-run, boot values this time
        @(posedge clk);
        for (int i = 1; i < NUM_FANS; i++) boot_power[i] <= 7'($urandom_range(100, 0));
        boot_power[0] <= 7'h64;
        rst_b <= 1'b0;
        boot_valid <= 1'b1;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        idle(2);
        @(posedge clk);
        for (int i = 0; i < NUM_FANS; i++) rd_reg(ADDR_POWER0 + 4'(i), 32'(boot_power[i]));
        idle(5);
        check(32'(switch_oe), 32'h1);
        results();
    end
endmodule : testbench
